// ---- cgc_top.v ----
/*
 * Clock generator control: pin mode and gain register, CPU clock source and
 * divider register, oscillator enables, CPU clock hold-off, APB slave.
 * Assumes pclk is the main system clock; the CPU clock is delivered as a
 * one-cycle enable pulse on pclk; clock pins and straps are asynchronous.
 */
// Summary of operation
// RQ1: Low-speed oscillator (240 kHz) runs after every reset, no software needed.
// RQ2: Software stop of low-speed oscillator works only if option strap allows.
// RQ3: Low-speed clock feeds only watchdog and timer unit, never the CPU.
// RQ4: Pin mode register takes bit or byte writes, resets to zero.
// RQ5: High-speed pin bits 7,6: 00/10 port, 01 crystal, 11 external.
// RQ6: Software sets gain bit above 10 MHz, clears it for 1-10 MHz.
// RQ7: Gain bit may change once per reset; program it before peripherals.
// RQ8: Crystal on CPU and gain set: withhold CPU clock 4.06 to 16.12 us.
// RQ9: External clock on CPU and gain set: withhold 160 external clocks.
// RQ10: Stop release with gain: internal time, external 160, crystal stabilisation.
// RQ11: Software changes high-speed pin bits only while main oscillator halted.
// RQ12: Subsystem mode: crystal-start forces crystal, else 00/10 port, 01, 11.
// RQ13: CPU divider register takes bit or byte writes, resets to 01H.
// RQ14: Source 0 divides main by 1..16; source 1 gives half subsystem clock.
// RQ15: Bit 5 reports active source, read-only; software checks it first.
// RQ16: Low-speed halt bit 1 set stops the oscillator, clear runs it.
// RQ17: Source or divider changes only at period end, no short pulses.
// RQ18: Source status updates only once the switch has completed.
`include "cgc_map.vh"

module cgc_top (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`CGC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg pready_ff,
  output reg [31:0] prdata_ff,
  output reg pslverr_ff,
  // Pins and straps from outside the pclk domain
  input wire ext_main_clk_pin,
  input wire sub_clk_pin,
  input wire option_ls_stoppable,
  input wire hs_osc_stable,
  // Same-domain status from the rest of the clock generator
  input wire main_uses_high_speed,
  input wire stop_release,
  input wire osc_stab_done,
  // Clock outputs and controls
  output reg cpu_clk_en_ff,
  output reg cpu_hold_ff,
  output reg osc_stab_start_ff,
  output reg low_speed_osc_run_ff,
  output reg hs_osc_run_ff,
  output reg main_osc_run_ff,
  output reg osc_gain_high_ff,
  output reg [1:0] hs_pin_mode_ff,
  output reg [1:0] sub_pin_mode_ff
);

  // ========================================================================
  // Addresses and states
  localparam [`CGC_ADDR_W-1:0] A_PIN_MODE = {`CGC_IDX_PIN_MODE, 2'b00};
  localparam [`CGC_ADDR_W-1:0] A_CPU_DIV = {`CGC_IDX_CPU_DIV, 2'b00};
  localparam [`CGC_ADDR_W-1:0] A_INT_OSC = {`CGC_IDX_INT_OSC, 2'b00};
  localparam [`CGC_ADDR_W-1:0] A_MAIN_OSC = {`CGC_IDX_MAIN_OSC, 2'b00};
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_TIME = 2'h1;
  localparam [1:0] ST_EXT = 2'h2;
  localparam [1:0] ST_OST = 2'h3;
  localparam integer HOLD_I = `CGC_HOLD_CYC, EXT_I = `CGC_EXT_HOLD_CLKS;
  localparam [7:0] HOLD_CYC = HOLD_I[7:0];
  localparam [7:0] EXT_CLKS = EXT_I[7:0];

  // ========================================================================
  // Decoding functions
  function [1:0] pin_mode;
    input ext_sel;
    input osc_sel;
    begin
      if (!osc_sel) begin
        pin_mode = `CGC_PIN_PORT;
      end else if (ext_sel) begin
        pin_mode = `CGC_PIN_EXT;
      end else begin
        pin_mode = `CGC_PIN_XTAL;
      end
    end
  endfunction

  // Last count value of one CPU clock period for a main clock divide code
  function [3:0] div_last;
    input [2:0] code;
    begin
      case (code)
        3'h0: div_last = 4'h0;
        3'h1: div_last = 4'h1;
        3'h2: div_last = 4'h3;
        3'h3: div_last = 4'h7;
        default: div_last = 4'hF;
      endcase
    end
  endfunction

  // ========================================================================
  // Synchronised pins
  wire [3:0] pins_sync;
  wire ext_clk_s = pins_sync[0];
  wire sub_clk_s = pins_sync[1];
  wire ls_stoppable_s = pins_sync[2];
  wire hs_stable_s = pins_sync[3];

  cgc_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in({hs_osc_stable, option_ls_stoppable, sub_clk_pin, ext_main_clk_pin}),
    .sync_out(pins_sync)
  );

  reg ext_clk_d_ff;
  reg sub_clk_d_ff;
  wire ext_rise = ext_clk_s & ~ext_clk_d_ff;
  wire sub_rise = sub_clk_s & ~sub_clk_d_ff;

  // ========================================================================
  // Registers
  reg [7:0] pin_mode_ff;
  reg [7:0] cpu_div_ff;
  reg [7:0] int_osc_ff;
  reg [7:0] main_osc_ff;
  reg gain_locked_ff;
  reg cur_sub_ff;
  reg [2:0] cur_div_ff;
  reg [3:0] div_cnt_ff;
  reg sub_phase_ff;
  reg [1:0] state_ff;
  reg hold_start_d_ff;
  reg [1:0] nxt_state;
  reg [31:0] nxt_rdata;
  reg nxt_err;

  // ========================================================================
  // APB decode: one wait state, write takes effect with pready high
  wire access = psel & penable;
  wire first_cyc = access & ~pready_ff;
  wire wr_en = access & pready_ff & pwrite & ~pslverr_ff;
  wire wr_pin = wr_en & (paddr == A_PIN_MODE);
  wire wr_div = wr_en & (paddr == A_CPU_DIV);
  wire wr_int = wr_en & (paddr == A_INT_OSC);
  wire wr_main = wr_en & (paddr == A_MAIN_OSC);
  wire [7:0] wdat = pwdata[7:0];

  // Gain may flip only once; later writes keep the stored value
  wire gain_wr_val = gain_locked_ff ? pin_mode_ff[`CGC_B_GAIN] : wdat[`CGC_B_GAIN]; // RQ7
  wire gain_rise = wr_pin & gain_wr_val & ~pin_mode_ff[`CGC_B_GAIN];

  always @* begin
    nxt_err = 1'b0;
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      A_PIN_MODE: nxt_rdata[7:0] = pin_mode_ff;
      A_CPU_DIV: begin
        nxt_rdata[7:0] = cpu_div_ff;
        nxt_rdata[`CGC_B_SRC_STAT] = cur_sub_ff; // RQ15
      end
      A_INT_OSC: begin
        nxt_rdata[7:0] = int_osc_ff;
        nxt_rdata[`CGC_B_HS_STABLE] = hs_stable_s;
      end
      A_MAIN_OSC: nxt_rdata[7:0] = main_osc_ff;
      default: nxt_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= first_cyc;
      if (first_cyc) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
        pslverr_ff <= nxt_err;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Register storage; reserved bits stay zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_mode_ff <= `CGC_RST_PIN_MODE; // RQ4
      cpu_div_ff <= `CGC_RST_CPU_DIV; // RQ13
      int_osc_ff <= `CGC_RST_INT_OSC; // RQ1
      main_osc_ff <= `CGC_RST_MAIN_OSC;
      gain_locked_ff <= 1'b0;
    end else if (ce) begin
      if (wr_pin) begin
        pin_mode_ff <= {wdat[7:4], 3'b000, gain_wr_val}; // RQ4
        if (gain_wr_val != pin_mode_ff[`CGC_B_GAIN]) begin
          gain_locked_ff <= 1'b1; // RQ7
        end
      end
      if (wr_div) begin
        cpu_div_ff <= {1'b0, wdat[6], 1'b0, wdat[4], 1'b0, wdat[2:0]}; // RQ13
      end
      if (wr_int) begin
        int_osc_ff <= {6'h00, wdat[1:0]}; // RQ16
      end
      if (wr_main) begin
        main_osc_ff <= {wdat[7], 7'h00};
      end
    end
  end

  // ========================================================================
  // Pin modes and oscillator enables
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_pin_mode_ff <= `CGC_PIN_PORT;
      sub_pin_mode_ff <= `CGC_PIN_PORT;
      low_speed_osc_run_ff <= 1'b1; // RQ1
      hs_osc_run_ff <= 1'b1;
      main_osc_run_ff <= 1'b0;
      osc_gain_high_ff <= 1'b0;
      ext_clk_d_ff <= 1'b0;
      sub_clk_d_ff <= 1'b0;
    end else if (ce) begin
      hs_pin_mode_ff <= pin_mode(pin_mode_ff[`CGC_B_HS_EXT],
                                 pin_mode_ff[`CGC_B_HS_OSC]); // RQ5
      if (cpu_div_ff[`CGC_B_SUB_XSTART]) begin
        sub_pin_mode_ff <= `CGC_PIN_XTAL; // RQ12
      end else begin
        sub_pin_mode_ff <= pin_mode(pin_mode_ff[`CGC_B_SUB_EXT],
                                    pin_mode_ff[`CGC_B_SUB_OSC]); // RQ12
      end
      // Halt request honoured only when the strap allows it; this clock
      // goes to the watchdog and timer unit, never into the CPU path
      low_speed_osc_run_ff <= ~(int_osc_ff[`CGC_B_LS_HALT] & ls_stoppable_s); // RQ2 RQ16 RQ3
      hs_osc_run_ff <= ~int_osc_ff[`CGC_B_HS_HALT];
      main_osc_run_ff <= ~main_osc_ff[`CGC_B_MAIN_HALT];
      osc_gain_high_ff <= pin_mode_ff[`CGC_B_GAIN];
      ext_clk_d_ff <= ext_clk_s;
      sub_clk_d_ff <= sub_clk_s;
    end
  end

  // ========================================================================
  // CPU clock hold-off sequencer
  wire hs_xtal = (hs_pin_mode_ff == `CGC_PIN_XTAL);
  wire hs_ext = (hs_pin_mode_ff == `CGC_PIN_EXT);
  wire on_hs = ~cur_sub_ff & main_uses_high_speed;
  wire gain_on = pin_mode_ff[`CGC_B_GAIN];
  wire hold_busy;
  reg hold_start;

  always @* begin
    nxt_state = state_ff;
    hold_start = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (gain_rise && on_hs && hs_xtal) begin
          nxt_state = ST_TIME; // RQ8
          hold_start = 1'b1;
        end else if (gain_rise && on_hs && hs_ext) begin
          nxt_state = ST_EXT; // RQ9
          hold_start = 1'b1;
        end else if (stop_release && gain_on && !cur_sub_ff) begin
          if (!main_uses_high_speed) begin
            nxt_state = ST_TIME; // RQ10
            hold_start = 1'b1;
          end else if (hs_ext) begin
            nxt_state = ST_EXT; // RQ10
            hold_start = 1'b1;
          end else if (hs_xtal) begin
            nxt_state = ST_OST; // RQ10
          end
        end
      end
      ST_TIME: begin
        if (!hold_busy && !hold_start_d_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_EXT: begin
        if (!hold_busy && !hold_start_d_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_OST: begin
        if (osc_stab_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  cgc_holdoff u_holdoff (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(hold_start),
    .tick((state_ff == ST_EXT) ? ext_rise : 1'b1),
    .limit((nxt_state == ST_EXT || state_ff == ST_EXT) ? EXT_CLKS : HOLD_CYC),
    .busy_ff(hold_busy)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      hold_start_d_ff <= 1'b0;
      cpu_hold_ff <= 1'b0;
      osc_stab_start_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      hold_start_d_ff <= hold_start;
      cpu_hold_ff <= (nxt_state != ST_IDLE); // RQ8 RQ9 RQ10
      osc_stab_start_ff <= (state_ff == ST_IDLE) && (nxt_state == ST_OST); // RQ10
    end
  end

  // ========================================================================
  // CPU clock enable generation
  // A new source or ratio is taken only at the end of a full period, so no
  // short pulse appears. If the subsystem clock is dead after a switch to
  // it, the CPU clock stops; software must start that clock first.
  wire req_sub = cpu_div_ff[`CGC_B_SRC_SEL];
  wire [2:0] req_div = cpu_div_ff[2:0];
  wire req_ok = (req_div <= `CGC_DIV_MAX); // RQ14
  wire main_end = ~cur_sub_ff & (div_cnt_ff == div_last(cur_div_ff));
  wire sub_end = cur_sub_ff & sub_rise & sub_phase_ff; // RQ14
  wire period_end = main_end | sub_end;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_sub_ff <= 1'b0;
      cur_div_ff <= 3'h1;
      div_cnt_ff <= 4'h0;
      sub_phase_ff <= 1'b0;
      cpu_clk_en_ff <= 1'b0;
    end else if (ce) begin
      cpu_clk_en_ff <= period_end & (state_ff == ST_IDLE) & ~cpu_hold_ff;
      if (period_end && req_ok) begin
        cur_sub_ff <= req_sub; // RQ17 RQ18
        cur_div_ff <= req_div; // RQ17
        div_cnt_ff <= 4'h0;
        sub_phase_ff <= 1'b0;
      end else if (period_end) begin
        div_cnt_ff <= 4'h0;
        sub_phase_ff <= 1'b0;
      end else begin
        div_cnt_ff <= div_cnt_ff + 4'h1;
        if (sub_rise) begin
          sub_phase_ff <= ~sub_phase_ff;
        end
      end
    end
  end

endmodule // cgc_top

// ---- cgc_map.vh ----
/*
 * Register map, field positions, reset values and timing counts of the
 * clock generator control block.
 * Assumes a 20 MHz pclk and word-aligned APB registers at four times the index.
 */
`ifndef CGC_MAP_VH
`define CGC_MAP_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define CGC_IDX_PIN_MODE 16'hFF9F
`define CGC_IDX_CPU_DIV 16'hFFFB
`define CGC_IDX_INT_OSC 16'hFFA0
`define CGC_IDX_MAIN_OSC 16'hFFA2
`define CGC_ADDR_W 18

// ==========================================================================
// Reset values
`define CGC_RST_PIN_MODE 8'h00
`define CGC_RST_CPU_DIV 8'h01
`define CGC_RST_INT_OSC 8'h00
`define CGC_RST_MAIN_OSC 8'h80

// ==========================================================================
// Field positions
`define CGC_B_HS_EXT 7
`define CGC_B_HS_OSC 6
`define CGC_B_SUB_EXT 5
`define CGC_B_SUB_OSC 4
`define CGC_B_GAIN 0
`define CGC_B_SUB_XSTART 6
`define CGC_B_SRC_STAT 5
`define CGC_B_SRC_SEL 4
`define CGC_B_HS_STABLE 7
`define CGC_B_LS_HALT 1
`define CGC_B_HS_HALT 0
`define CGC_B_MAIN_HALT 7
`define CGC_DIV_MAX 3'h4

// ==========================================================================
// Pin modes
`define CGC_PIN_PORT 2'h0
`define CGC_PIN_XTAL 2'h1
`define CGC_PIN_EXT 2'h2

// ==========================================================================
// Timing
`define CGC_CLK_MHZ 20
`define CGC_LS_OSC_KHZ 240
`define CGC_HOLD_MIN_NS 4060
`define CGC_HOLD_MAX_NS 16120
`define CGC_HOLD_CYC ((`CGC_HOLD_MIN_NS * `CGC_CLK_MHZ + 999) / 1000)
`define CGC_EXT_HOLD_CLKS 160

`endif

// ---- cgc_sync.v ----
/*
 * Two-flop synchronisers, one per bit, for inputs from outside pclk.
 * Assumes each bit is an independent level; no bus coherence is kept.
 */
module cgc_sync #(
  parameter W = 4
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // Data
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else if (ce) begin
          meta_ff <= async_in[i];
          sync_ff <= meta_ff;
        end
      end
      assign sync_out[i] = sync_ff;
    end
  endgenerate

endmodule // cgc_sync

// ---- cgc_holdoff.v ----
/*
 * Hold-off counter: after start, stays busy until limit ticks have passed.
 * Assumes start is a one-cycle pulse and limit is at least one.
 */
module cgc_holdoff (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // Control
  input wire start,
  input wire tick,
  input wire [7:0] limit,
  output reg busy_ff
);

  reg [7:0] cnt_ff;
  wire [7:0] nxt_cnt = cnt_ff + 8'h01;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (ce) begin
      if (start) begin
        busy_ff <= 1'b1;
        cnt_ff <= 8'h00;
      end else if (busy_ff && tick) begin
        cnt_ff <= nxt_cnt;
        if (nxt_cnt == limit) begin
          busy_ff <= 1'b0;
        end
      end
    end
  end

endmodule // cgc_holdoff

// ---- cgc_top_props.sv ----
/*
 * Assertion checker for cgc_top, bound to it at the foot of this file.
 * Assumes ce is held high and the pins change just after pclk edges.
 */
`include "cgc_map.vh"

module cgc_top_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`CGC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready_ff,
  input wire pslverr_ff,
  // Pins and status
  input wire ext_main_clk_pin,
  input wire option_ls_stoppable,
  input wire main_uses_high_speed,
  // Clock outputs
  input wire cpu_clk_en_ff,
  input wire cpu_hold_ff,
  input wire low_speed_osc_run_ff,
  input wire osc_gain_high_ff,
  input wire [1:0] hs_pin_mode_ff
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Helper logic
  wire [15:0] idx = paddr[17:2];
  wire acc = psel && penable && pready_ff;
  wire mapped = idx == `CGC_IDX_PIN_MODE || idx == `CGC_IDX_CPU_DIV ||
    idx == `CGC_IDX_INT_OSC || idx == `CGC_IDX_MAIN_OSC;
  wire wr_pin = acc && pwrite && idx == `CGC_IDX_PIN_MODE;
  reg [1:0] wd_ff;
  reg gain_prev_ff;
  reg [1:0] gain_chg_ff;
  reg ext_prev_ff;
  reg [8:0] ecnt_ff;

  function automatic logic [1:0] hs_dec(input logic [1:0] c);
    hs_dec = c == 2'h3 ? `CGC_PIN_EXT : (c == 2'h1 ? `CGC_PIN_XTAL : `CGC_PIN_PORT);
  endfunction

  // Raw pin edges counted only inside a hold, so each window stands alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_ff <= 2'h0;
      gain_prev_ff <= 1'b0;
      gain_chg_ff <= 2'h0;
      ext_prev_ff <= 1'b0;
      ecnt_ff <= 9'h000;
    end else begin
      if (wr_pin) begin
        wd_ff <= pwdata[7:6];
      end
      if (osc_gain_high_ff != gain_prev_ff && gain_chg_ff != 2'h3) begin
        gain_chg_ff <= gain_chg_ff + 2'h1;
      end
      gain_prev_ff <= osc_gain_high_ff;
      ext_prev_ff <= ext_main_clk_pin;
      ecnt_ff <= cpu_hold_ff ? ecnt_ff + {8'h00, ext_main_clk_pin && !ext_prev_ff} : 9'h000;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ls_reset_run_a: assert property (
    $rose(presetn) |-> low_speed_osc_run_ff)
    else $error("Low-speed oscillator idle after reset");
  ls_strap_a: assert property (
    !option_ls_stoppable [*4] |-> low_speed_osc_run_ff)
    else $error("Low-speed oscillator stopped without strap");
  gain_once_a: assert property (
    gain_chg_ff <= 2'h1)
    else $error("Gain bit changed twice");
  xtal_hold_a: assert property (
    $rose(cpu_hold_ff) && hs_pin_mode_ff == `CGC_PIN_XTAL && main_uses_high_speed |->
    (cpu_hold_ff throughout ##81 1) ##[1:241] !cpu_hold_ff)
    else $error("Crystal hold length out of range");
  ext_hold_a: assert property (
    $fell(cpu_hold_ff) && hs_pin_mode_ff == `CGC_PIN_EXT |->
    ecnt_ff >= 9'h09D && ecnt_ff <= 9'h0A2)
    else $error("External hold edge count wrong");
  hold_gate_a: assert property (
    cpu_hold_ff && $past(cpu_hold_ff) |-> !cpu_clk_en_ff)
    else $error("CPU clock pulse during hold");
  hs_mode_a: assert property (
    wr_pin |-> ##[1:2] hs_pin_mode_ff == hs_dec(wd_ff))
    else $error("High-speed pin mode decode wrong");
  apb_wait_a: assert property (
    psel && !penable |-> ##2 pready_ff)
    else $error("APB ready not after one wait state");
  apb_err_a: assert property (
    acc |-> pslverr_ff == !mapped)
    else $error("APB error flag wrong for address");

  cover property ($rose(cpu_hold_ff) && hs_pin_mode_ff == `CGC_PIN_XTAL);
  cover property ($fell(cpu_hold_ff) && hs_pin_mode_ff == `CGC_PIN_EXT);
  cover property (acc && pslverr_ff);
  cover property (wr_pin);
endmodule // cgc_top_props

bind cgc_top cgc_top_props u_props (.*);

// ---- clock_mode_and_cpu_clock_select_tb.sv ----
/*
 * Self-checking testbench for cgc_top: APB register access, pin modes,
 * CPU clock division and source switch, low-speed oscillator, hold-off.
 * Assumes the design's register map header and a 20 MHz pclk.
 */
`include "cgc_map.vh"

module clock_mode_and_cpu_clock_select_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Stimulus and wiring
  localparam logic [17:0] A_PIN = {`CGC_IDX_PIN_MODE, 2'h0};
  localparam logic [17:0] A_DIV = {`CGC_IDX_CPU_DIV, 2'h0};
  localparam logic [17:0] A_INT = {`CGC_IDX_INT_OSC, 2'h0};
  localparam logic [17:0] A_MAIN = {`CGC_IDX_MAIN_OSC, 2'h0};
  // Longest allowed hold in pclk cycles
  localparam int HOLD_MAX = `CGC_HOLD_MAX_NS * `CGC_CLK_MHZ / 1000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [1:0] ext_cnt = 2'h0;
  logic [3:0] sub_cnt = 4'h0;
  logic option_ls_stoppable = 1'b0;
  logic hs_osc_stable = 1'b0;
  logic main_uses_high_speed = 1'b0;
  logic stop_release = 1'b0;
  logic osc_stab_done = 1'b0;
  wire ext_main_clk_pin = ext_cnt[1];
  wire sub_clk_pin = sub_cnt[3];
  wire pready_ff, pslverr_ff, cpu_clk_en_ff, cpu_hold_ff, osc_stab_start_ff;
  wire low_speed_osc_run_ff, hs_osc_run_ff, main_osc_run_ff, osc_gain_high_ff;
  wire [31:0] prdata_ff;
  wire [1:0] hs_pin_mode_ff, sub_pin_mode_ff;
  int err_total = 0;
  int checked = 0;

  cgc_top dut (.*);

  always #25 pclk = ~pclk;

  // External pin period 4 pclk, subsystem pin period 16 pclk
  always @(posedge pclk) begin
    ext_cnt <= ext_cnt + 2'h1;
    sub_cnt <= sub_cnt + 4'h1;
  end

  // ==========================================================================
  // Shared tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task apb(input logic [17:0] a, input logic w, input logic [7:0] d,
           output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_ff !== 1'b1 && n < 50);
    r = prdata_ff;
    e = pslverr_ff;
    if (pready_ff !== 1'b1) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task per(output int p);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (cpu_clk_en_ff !== 1'b1 && n < 100);
    p = 0;
    do begin
      @(posedge pclk);
      p++;
    end while (cpu_clk_en_ff !== 1'b1 && p < 100);
  endtask

  task hold_len(output int len);
    int n;
    n = 0;
    while (cpu_hold_ff !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    len = 0;
    while (cpu_hold_ff === 1'b1 && len < 2000) begin
      @(posedge pclk);
      len++;
    end
  endtask

  task stop_pulse;
    @(posedge pclk);
    stop_release <= 1'b1;
    @(posedge pclk);
    stop_release <= 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  task t_reset;
    logic [31:0] r;
    logic e;
    chk("ls run", 1, low_speed_osc_run_ff);
    chk("hs osc run", 1, hs_osc_run_ff);
    chk("main osc run", 0, main_osc_run_ff);
    apb(A_MAIN, 1'b0, 8'h00, r, e);
    chk("main osc reg", 32'h80, r);
    apb(A_PIN, 1'b0, 8'h00, r, e);
    chk("pin mode reg", 32'h00, r);
    apb(A_DIV, 1'b0, 8'h00, r, e);
    chk("cpu div reg", 32'h01, r);
    apb(A_DIV, 1'b1, 8'h21, r, e);
    apb(A_DIV, 1'b0, 8'h00, r, e);
    chk("status read-only", 32'h01, r);
    apb(18'h00000, 1'b0, 8'h00, r, e);
    chk("unmapped err", 1, e);
  endtask

  task t_pins;
    logic [31:0] r;
    logic e;
    logic [1:0] cv;
    logic [1:0] ev;
    for (int c = 0; c < 4; c++) begin
      cv = c[1:0];
      ev = cv == 2'h3 ? `CGC_PIN_EXT : (cv == 2'h1 ? `CGC_PIN_XTAL : `CGC_PIN_PORT);
      apb(A_PIN, 1'b1, {cv, cv, 4'h0}, r, e);
      cyc(2);
      chk("hs pin mode", ev, hs_pin_mode_ff);
      chk("sub pin mode", ev, sub_pin_mode_ff);
    end
    apb(A_PIN, 1'b0, 8'h00, r, e);
    chk("pin mode reg", 32'hF0, r);
    apb(A_DIV, 1'b1, 8'h41, r, e);
    cyc(2);
    chk("sub crystal start", `CGC_PIN_XTAL, sub_pin_mode_ff);
    apb(A_DIV, 1'b1, 8'h01, r, e);
    apb(A_PIN, 1'b1, 8'h00, r, e);
  endtask

  task t_div;
    logic [31:0] r;
    logic e;
    int p;
    for (int d = 0; d < 6; d++) begin
      apb(A_DIV, 1'b1, d[7:0], r, e);
      per(p);
      per(p);
      chk("cpu period", d < 5 ? 1 << d : 16, p);
    end
    apb(A_DIV, 1'b1, 8'h10, r, e);
    // First subsystem period after the switch may be partial
    per(p);
    per(p);
    per(p);
    chk("sub period", 32, p);
    apb(A_DIV, 1'b0, 8'h00, r, e);
    chk("source status", 32'h30, r);
    apb(A_DIV, 1'b1, 8'h01, r, e);
    per(p);
    per(p);
    apb(A_DIV, 1'b0, 8'h00, r, e);
    chk("source status", 32'h01, r);
  endtask

  task t_ls;
    logic [31:0] r;
    logic e;
    hs_osc_stable <= 1'b1;
    apb(A_INT, 1'b1, 8'h02, r, e);
    apb(A_INT, 1'b0, 8'h00, r, e);
    chk("int osc reg", 32'h82, r);
    cyc(5);
    chk("ls run", 1, low_speed_osc_run_ff);
    option_ls_stoppable <= 1'b1;
    cyc(5);
    chk("ls run", 0, low_speed_osc_run_ff);
    apb(A_INT, 1'b1, 8'h00, r, e);
    cyc(3);
    chk("ls run", 1, low_speed_osc_run_ff);
    option_ls_stoppable <= 1'b0;
  endtask

  task t_hold;
    logic [31:0] r;
    logic e;
    logic seen;
    int len;
    main_uses_high_speed <= 1'b1;
    apb(A_PIN, 1'b1, 8'h40, r, e);
    apb(A_PIN, 1'b1, 8'h41, r, e);
    hold_len(len);
    chk("crystal hold", 1, len >= `CGC_HOLD_CYC && len <= HOLD_MAX);
    apb(A_PIN, 1'b1, 8'h40, r, e);
    apb(A_PIN, 1'b0, 8'h00, r, e);
    chk("gain kept", 32'h41, r);
    chk("gain out", 1, osc_gain_high_ff);
    apb(A_PIN, 1'b1, 8'hC1, r, e);
    stop_pulse;
    hold_len(len);
    chk("external hold", 1, len >= 630 && len <= 645);
    apb(A_PIN, 1'b1, 8'h41, r, e);
    stop_pulse;
    seen = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      if (osc_stab_start_ff === 1'b1) seen = 1'b1;
    end
    chk("stab start", 1, seen);
    cyc(100);
    chk("stab hold", 1, cpu_hold_ff);
    osc_stab_done <= 1'b1;
    cyc(4);
    chk("stab hold", 0, cpu_hold_ff);
    osc_stab_done <= 1'b0;
    main_uses_high_speed <= 1'b0;
    stop_pulse;
    hold_len(len);
    chk("internal hold", 1, len >= `CGC_HOLD_CYC && len <= HOLD_MAX);
  endtask

  task test_done;
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_pins;
    t_div;
    t_ls;
    t_hold;
    test_done;
  end

  // Whole run needs under two thousand cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    test_done;
  end
endmodule // clock_mode_and_cpu_clock_select_tb
